/* File: rtl/lfi_pkg.sv */
/*
  Shared constants of the LED driver fault interrupt register block:
  register indices, field positions, reset values and enable codes.
  Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
package lfi_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] LFI_IDX_LED_EN   = 8'h0c;
  localparam logic [7:0] LFI_IDX_SUPPLY   = 8'h0e;
  localparam logic [7:0] LFI_IDX_LED_EVT  = 8'h20;
  localparam logic [7:0] LFI_IDX_SUP_MASK = 8'h21;

  // Enable field write commands and read codes
  localparam logic [1:0] LFI_EN_CMD_OFF   = 2'h1;
  localparam logic [1:0] LFI_EN_CMD_ON    = 2'h3;
  localparam logic [1:0] LFI_EN_RD_OFF    = 2'h0;
  localparam logic [1:0] LFI_EN_RD_ON     = 2'h2;

  // Enable field slots (field k sits at bits 2k+1:2k)
  localparam int         LFI_EN_GLOBAL    = 3;
  localparam int         LFI_EN_TIMEOUT   = 2;
  localparam int         LFI_EN_STRING    = 1;
  localparam int         LFI_EN_LED       = 0;
  localparam int         LFI_EN_FIELDS    = 4;

  // Supply fault slots: status at 2k+1, clear at 2k
  localparam int         LFI_SUP_CHECKSUM = 7;
  localparam int         LFI_SUP_SYNCCLK  = 6;
  localparam int         LFI_SUP_PUMP     = 5;
  localparam int         LFI_SUP_PUMPCAP  = 4;
  localparam int         LFI_SUP_IN_OC    = 3;
  localparam int         LFI_SUP_CORE_UV  = 2;
  localparam int         LFI_SUP_IN_OV    = 1;
  localparam int         LFI_SUP_IN_UV    = 0;
  localparam int         LFI_SUP_FAULTS   = 8;

  // LED event slots of the event status register
  localparam int         LFI_EVT_TIMEOUT  = 2;
  localparam int         LFI_EVT_STRING   = 1;
  localparam int         LFI_EVT_LED      = 0;
  localparam int         LFI_LED_EVENTS   = 3;

  // Reset values
  localparam logic [15:0] LFI_RST_LED_EN   = 16'h00aa;
  localparam logic [15:0] LFI_RST_SUPPLY   = 16'h0000;
  localparam logic [7:0]  LFI_RST_SUP_MASK = 8'hff;
  localparam logic        LFI_RST_EN_BIT   = 1'b1;

  // Byte address of a register index
  function automatic logic [7:0] lfi_byte_addr(input logic [7:0] idx);
    lfi_byte_addr = {idx[5:0], 2'b00};
  endfunction

endpackage

/* File: rtl/lfi_en_field.sv */
/*
  One two-bit interrupt enable field with command style writes.
  Assumes the write strobe is a single-cycle pulse on clk_i.
*/
`timescale 1ns/100ps
module lfi_en_field
  import lfi_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire logic [1:0] wdata_i,
  output logic            en_o,
  output logic [1:0]      rdata_o
);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      en_o <= RST_VAL;
    else if (wr_i && wdata_i == LFI_EN_CMD_ON)
      en_o <= 1'b1; // RULE_01
    else if (wr_i && wdata_i == LFI_EN_CMD_OFF)
      en_o <= 1'b0; // RULE_01
  end

  // Codes 0h and 2h fall through and hold the state
  assign rdata_o = en_o ? LFI_EN_RD_ON : LFI_EN_RD_OFF; // RULE_02

endmodule

/* File: rtl/lfi_fault_flag.sv */
/*
  One recorded fault with its paired status and clear write bits.
  Assumes the fault input is already synchronised to clk_i.
*/
`timescale 1ns/100ps
module lfi_fault_flag
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       fault_i,
  input  wire logic       wr_i,
  input  wire logic [1:0] pair_i,
  output logic            flag_o
);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_o <= 1'b0; // RULE_08
    else if (fault_i)
      flag_o <= 1'b1;
    else if (wr_i && pair_i == 2'b11)
      flag_o <= 1'b0; // RULE_09
  end

endmodule

/* File: rtl/lfi_regs.sv */
/*
  Fault interrupt register block of an LED driver: LED interrupt enables,
  supply fault status with paired clears, LED event status and supply
  mask, one level interrupt output.
  Assumes a classic Wishbone master on clk_i and fault detector levels
  arriving asynchronously.
*/
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
// Operation
// RULE_01 - Enable field write: 1h disables, 3h enables the interrupt.
// RULE_02 - Enable field reads 0h when disabled, 2h when enabled.
// RULE_03 - Global enable at bits 7-6, enabled after reset.
// RULE_04 - Serial bus timeout enable at bits 5-4, enabled after reset.
// RULE_05 - Bad string configuration enable at bits 3-2, enabled at reset.
// RULE_06 - One LED fault enable at bits 1-0, enabled after reset.
// RULE_07 - Enable register bits 15-8 reserved, zero, no function.
// RULE_08 - Supply status bit reads 1 when fault recorded, resets to 0.
// RULE_09 - Writing status and clear bit together clears fault and pin.
// RULE_10 - Checksum fault status bit 15, clear bit 14.
// RULE_11 - Missing sync clock fault status bit 13, clear bit 12.
// RULE_12 - Pump fault 11/10, missing pump capacitor 9/8.
// RULE_13 - Low byte: over-current, core UV, input OV, input UV pairs.
// RULE_14 - Writing only one bit of a pair changes nothing.
// RULE_15 - Pin asserts only with global enable and an enabled fault.
// RULE_16 - Enable field writes of 0h or 2h hold the state.
module lfi_regs
  import lfi_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  supply_fault_i,
  input  wire logic [2:0]  led_event_i,
  output logic             irq_o
);

  logic [7:0]  sup_meta;
  logic [7:0]  sup_sync;
  logic [2:0]  evt_meta;
  logic [2:0]  evt_sync;
  logic        req;
  logic        wr_now;
  logic        hit_led_en;
  logic        hit_supply;
  logic        hit_evt;
  logic        hit_mask;
  logic        wr_lo;
  logic [3:0]  en_bits;
  logic [7:0]  en_rd;
  logic [7:0]  sup_flags;
  logic [15:0] sup_rd;
  logic [2:0]  evt_flags;
  logic [7:0]  sup_mask;
  logic [2:0]  evt_en;
  logic [31:0] next_rdata;
  logic        next_irq;

  // Input synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sup_meta <= 8'h00;
      sup_sync <= 8'h00;
      evt_meta <= 3'h0;
      evt_sync <= 3'h0;
    end
    else
    begin
      sup_meta <= supply_fault_i;
      sup_sync <= sup_meta;
      evt_meta <= led_event_i;
      evt_sync <= evt_meta;
    end
  end

  // Bus decode
  assign req        = wb_cyc_i & wb_stb_i;
  assign wr_now     = req & wb_we_i & wb_ack_o;
  assign hit_led_en = wb_adr_i == lfi_byte_addr(LFI_IDX_LED_EN);
  assign hit_supply = wb_adr_i == lfi_byte_addr(LFI_IDX_SUPPLY);
  assign hit_evt    = wb_adr_i == lfi_byte_addr(LFI_IDX_LED_EVT);
  assign hit_mask   = wb_adr_i == lfi_byte_addr(LFI_IDX_SUP_MASK);
  assign wr_lo      = wr_now & wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req & ~wb_ack_o;
  end

  // LED interrupt enable fields, all in the low byte
  genvar k;
  generate
    for (k = 0; k < LFI_EN_FIELDS; k++)
    begin : g_en
      lfi_en_field #(
        .RST_VAL (LFI_RST_EN_BIT)
      ) u_field (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_i    (wr_lo & hit_led_en), // RULE_16
        .wdata_i (wb_dat_i[2*k+1 -: 2]),
        .en_o    (en_bits[k]),
        .rdata_o (en_rd[2*k+1 -: 2])
      );
    end
  endgenerate

  assign evt_en[LFI_EVT_TIMEOUT] = en_bits[LFI_EN_TIMEOUT]; // RULE_04
  assign evt_en[LFI_EVT_STRING]  = en_bits[LFI_EN_STRING]; // RULE_05
  assign evt_en[LFI_EVT_LED]     = en_bits[LFI_EN_LED]; // RULE_06

  // Supply faults: pair k holds status 2k+1 and clear 2k
  generate
    for (k = 0; k < LFI_SUP_FAULTS; k++)
    begin : g_sup
      lfi_fault_flag u_flag (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .fault_i (sup_sync[k]),
        .wr_i    (wr_now & hit_supply & wb_sel_i[k/4]), // RULE_14
        .pair_i  (wb_dat_i[2*k+1 -: 2]), // RULE_09
        .flag_o  (sup_flags[k])
      );
      assign sup_rd[2*k+1] = sup_flags[k]; // RULE_10 RULE_11 RULE_12 RULE_13
      assign sup_rd[2*k]   = 1'b0;
    end
  endgenerate

  // LED event status, write one to clear, new event wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_flags <= 3'h0;
    else if (wr_lo && hit_evt)
      evt_flags <= (evt_flags & ~wb_dat_i[2:0]) | evt_sync;
    else
      evt_flags <= evt_flags | evt_sync;
  end

  // Supply fault mask, one bit per pair
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sup_mask <= LFI_RST_SUP_MASK;
    else if (wr_lo && hit_mask)
      sup_mask <= wb_dat_i[7:0];
  end

  // Read data
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit_led_en)
      next_rdata[7:0] = en_rd; // RULE_02 RULE_03 RULE_07
    else if (hit_supply)
      next_rdata[15:0] = sup_rd;
    else if (hit_evt)
      next_rdata[2:0] = evt_flags;
    else if (hit_mask)
      next_rdata[7:0] = sup_mask;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_ack_o && !wb_we_i)
      wb_dat_o <= next_rdata;
  end

  // Interrupt pin
  assign next_irq = en_bits[LFI_EN_GLOBAL] &
                    (|(sup_flags & sup_mask) | |(evt_flags & evt_en)); // RULE_15

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= next_irq;
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [7:0] pair_wr_one;
  always_comb
  begin
    pair_wr_one = 8'h00;
    for (int i = 0; i < LFI_SUP_FAULTS; i++)
      pair_wr_one[i] = wb_dat_i[2*i+1] ^ wb_dat_i[2*i];
  end

  enable_on_a : assert property ( // RULE_01
    wr_lo && hit_led_en && wb_dat_i[1:0] == LFI_EN_CMD_ON
    |=> en_bits[LFI_EN_LED])
    else $error("Enable command 3h did not enable the field");

  enable_off_a : assert property ( // RULE_01
    wr_lo && hit_led_en && wb_dat_i[7:6] == LFI_EN_CMD_OFF
    |=> !en_bits[LFI_EN_GLOBAL] ##1 !irq_o)
    else $error("Enable command 1h did not disable the field");

  enable_read_a : assert property ( // RULE_02
    req && !wb_we_i && !wb_ack_o && hit_led_en
    |=> wb_ack_o && wb_dat_o[7:6] == {$past(en_bits[LFI_EN_GLOBAL]), 1'b0})
    else $error("Enable field read code is wrong");

  enable_reset_a : assert property ( // RULE_03
    $fell(rst_i) |-> en_rd == LFI_RST_LED_EN[7:0])
    else $error("Enable register reset value is wrong");

  reserved_zero_a : assert property ( // RULE_07
    wb_ack_o && hit_led_en && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("Reserved enable bits read nonzero");

  flag_reset_a : assert property ( // RULE_08
    $fell(rst_i) |-> sup_flags == LFI_RST_SUPPLY[7:0] && !irq_o)
    else $error("Supply flags not zero after reset");

  pair_clear_a : assert property ( // RULE_09
    wr_now && hit_supply && wb_sel_i[1] && wb_dat_i[15:14] == 2'b11 &&
    !sup_sync[LFI_SUP_CHECKSUM]
    |=> !sup_flags[LFI_SUP_CHECKSUM])
    else $error("Paired clear did not clear the checksum fault");

  half_pair_a : assert property ( // RULE_14
    wr_now && hit_supply && sup_flags[LFI_SUP_IN_UV] && pair_wr_one[0]
    |=> sup_flags[LFI_SUP_IN_UV])
    else $error("Single bit write changed a recorded fault");

  set_wins_a : assert property ( // RULE_09
    sup_sync[LFI_SUP_PUMP] |=> sup_flags[LFI_SUP_PUMP])
    else $error("Fault lost against a clear");

  irq_gate_a : assert property ( // RULE_15
    irq_o |-> $past(en_bits[LFI_EN_GLOBAL]) &&
    ($past(|(sup_flags & sup_mask)) || $past(|(evt_flags & evt_en))))
    else $error("Interrupt raised without an enabled fault");

  hold_code_a : assert property ( // RULE_16
    wr_lo && hit_led_en && !wb_dat_i[2] |=> $stable(en_bits[LFI_EN_STRING]))
    else $error("Enable code 0h or 2h changed the field");

  hold_global_a : assert property ( // RULE_16
    wr_lo && hit_led_en && !wb_dat_i[6] |=> $stable(en_bits[LFI_EN_GLOBAL]))
    else $error("Enable code 0h or 2h changed the global field");

  timeout_on_a : assert property ( // RULE_01
    wr_lo && hit_led_en && wb_dat_i[5:4] == LFI_EN_CMD_ON
    |=> en_bits[LFI_EN_TIMEOUT])
    else $error("Enable command 3h did not enable the timeout field");

  timeout_off_a : assert property ( // RULE_01
    wr_lo && hit_led_en && wb_dat_i[5:4] == LFI_EN_CMD_OFF
    |=> !en_bits[LFI_EN_TIMEOUT])
    else $error("Enable command 1h did not disable the timeout field");

  string_on_a : assert property ( // RULE_01
    wr_lo && hit_led_en && wb_dat_i[3:2] == LFI_EN_CMD_ON
    |=> en_bits[LFI_EN_STRING])
    else $error("Enable command 3h did not enable the string field");

  led_off_a : assert property ( // RULE_01
    wr_lo && hit_led_en && wb_dat_i[1:0] == LFI_EN_CMD_OFF
    |=> !en_bits[LFI_EN_LED])
    else $error("Enable command 1h did not disable the LED field");

  timeout_read_a : assert property ( // RULE_04
    req && !wb_we_i && !wb_ack_o && hit_led_en
    |=> wb_dat_o[5:4] == {$past(en_bits[LFI_EN_TIMEOUT]), 1'b0})
    else $error("Timeout enable read from the wrong field");

  string_read_a : assert property ( // RULE_05
    req && !wb_we_i && !wb_ack_o && hit_led_en
    |=> wb_dat_o[3:2] == {$past(en_bits[LFI_EN_STRING]), 1'b0})
    else $error("String enable read from the wrong field");

  led_read_a : assert property ( // RULE_06
    req && !wb_we_i && !wb_ack_o && hit_led_en
    |=> wb_dat_o[1:0] == {$past(en_bits[LFI_EN_LED]), 1'b0})
    else $error("LED enable read from the wrong field");

  checksum_read_a : assert property ( // RULE_10
    req && !wb_we_i && !wb_ack_o && hit_supply
    |=> wb_dat_o[15] == $past(sup_flags[LFI_SUP_CHECKSUM]))
    else $error("Checksum fault read from the wrong bit");

  syncclk_read_a : assert property ( // RULE_11
    req && !wb_we_i && !wb_ack_o && hit_supply
    |=> wb_dat_o[13] == $past(sup_flags[LFI_SUP_SYNCCLK]))
    else $error("Sync clock fault read from the wrong bit");

  pump_read_a : assert property ( // RULE_12
    req && !wb_we_i && !wb_ack_o && hit_supply
    |=> wb_dat_o[11] == $past(sup_flags[LFI_SUP_PUMP]) &&
        wb_dat_o[9] == $past(sup_flags[LFI_SUP_PUMPCAP]))
    else $error("Pump faults read from the wrong bits");

  low_byte_read_a : assert property ( // RULE_13
    req && !wb_we_i && !wb_ack_o && hit_supply
    |=> wb_dat_o[7] == $past(sup_flags[LFI_SUP_IN_OC]) &&
        wb_dat_o[5] == $past(sup_flags[LFI_SUP_CORE_UV]) &&
        wb_dat_o[3] == $past(sup_flags[LFI_SUP_IN_OV]) &&
        wb_dat_o[1] == $past(sup_flags[LFI_SUP_IN_UV]))
    else $error("Low byte supply faults read from the wrong bits");

  clear_read_zero_a : assert property ( // RULE_09
    wb_ack_o && hit_supply && !wb_we_i
    |-> (wb_dat_o[15:0] & 16'h5555) == 16'h0000)
    else $error("A supply clear bit read nonzero");

  irq_low_a : assert property ( // RULE_15
    !en_bits[LFI_EN_GLOBAL] |=> !irq_o)
    else $error("Interrupt raised with the global enable off");

  irq_high_a : assert property ( // RULE_15
    en_bits[LFI_EN_GLOBAL] && (sup_flags & sup_mask) != 8'h00
    |=> irq_o)
    else $error("Enabled supply fault did not raise the interrupt");

  half_pair_hi_a : assert property ( // RULE_14
    wr_now && hit_supply && sup_flags[LFI_SUP_CHECKSUM] && pair_wr_one[7]
    |=> sup_flags[LFI_SUP_CHECKSUM])
    else $error("Single bit write changed the checksum fault");

  flag_quiet_a : assert property ( // RULE_08
    !sup_sync[LFI_SUP_IN_OV] && !sup_flags[LFI_SUP_IN_OV]
    |=> !sup_flags[LFI_SUP_IN_OV])
    else $error("Supply fault recorded without a fault");

endmodule

/* File: bench/tb.sv */
/*
  Self-checking bench of the fault interrupt register block.
  Assumes a single 40 MHz clock and a one-cycle classic Wishbone answer.
*/
`timescale 1ns/100ps
module tb;
  import lfi_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  supply_fault_i;
  logic [2:0]  led_event_i;
  logic        irq_o;
  logic [31:0] rd_val;
  logic [31:0] exp_en;
  int          miscompares;
  int          samples_checked;

  lfi_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .supply_fault_i(supply_fault_i),
    .led_event_i(led_event_i), .irq_o(irq_o));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task tally_and_finish;
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] ex);
    samples_checked++;
    if (seen !== ex)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, ex, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1)
    begin
      miscompares++;
      tally_and_finish();
    end
    rd_val = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task wait_irq(input logic ex);
    int n;
    for (n = 0; n < 16 && irq_o !== ex; n++)
      @(posedge clk_i);
    chk("irq_o", {31'h0, irq_o}, {31'h0, ex});
    if (irq_o !== ex)
      tally_and_finish();
  endtask

  task reset_values;
    wb_xfer(1'b0, 8'h30, 32'h0);
    chk("led_en", rd_val, 32'h0000_00aa);
    wb_xfer(1'b0, 8'h38, 32'h0);
    chk("supply", rd_val, 32'h0);
    wb_xfer(1'b0, 8'h84, 32'h0);
    chk("sup_mask", rd_val, 32'h0000_00ff);
    wb_xfer(1'b0, 8'h44, 32'h0);
    chk("unmapped", rd_val, 32'h0);
  endtask

  task enable_fields;
    exp_en = 32'h0000_00aa;
    for (int k = 0; k < LFI_EN_FIELDS; k++)
    begin
      wb_xfer(1'b1, 8'h30, 32'h1 << (2 * k));
      exp_en[2*k+:2] = 2'h0;
      wb_xfer(1'b0, 8'h30, 32'h0);
      chk("en_off", rd_val, exp_en);
      wb_xfer(1'b1, 8'h30, 32'h0000_ff00 | (32'h2 << (2 * k)));
      wb_xfer(1'b0, 8'h30, 32'h0);
      chk("en_hold", rd_val, exp_en);
      wb_xfer(1'b1, 8'h30, 32'h3 << (2 * k));
      exp_en[2*k+:2] = 2'h2;
      wb_xfer(1'b1, 8'h30, 32'h0);
      wb_xfer(1'b0, 8'h30, 32'h0);
      chk("en_on", rd_val, exp_en);
    end
  endtask

  task supply_faults;
    for (int k = 0; k < LFI_SUP_FAULTS; k++)
    begin
      @(posedge clk_i);
      supply_fault_i <= 8'h1 << k;
      repeat (2) @(posedge clk_i);
      supply_fault_i <= 8'h0;
      wait_irq(1'b1);
      repeat (4) @(posedge clk_i);
      wb_xfer(1'b0, 8'h38, 32'h0);
      chk("flag", rd_val, 32'h2 << (2 * k));
      wb_xfer(1'b1, 8'h38, 32'h2 << (2 * k));
      wb_xfer(1'b1, 8'h38, 32'h1 << (2 * k));
      wb_xfer(1'b0, 8'h38, 32'h0);
      chk("half_pair", rd_val, 32'h2 << (2 * k));
      chk("irq_held", {31'h0, irq_o}, 32'h1);
      wb_xfer(1'b1, 8'h38, 32'h3 << (2 * k));
      wb_xfer(1'b0, 8'h38, 32'h0);
      chk("cleared", rd_val, 32'h0);
      wait_irq(1'b0);
    end
  endtask

  task irq_gating;
    for (int k = 0; k < LFI_LED_EVENTS; k++)
    begin
      @(posedge clk_i);
      led_event_i <= 3'h1 << k;
      repeat (2) @(posedge clk_i);
      led_event_i <= 3'h0;
      wait_irq(1'b1);
      wb_xfer(1'b1, 8'h30, 32'h1 << (2 * k));
      wait_irq(1'b0);
      wb_xfer(1'b1, 8'h30, 32'h3 << (2 * k));
      wait_irq(1'b1);
      repeat (4) @(posedge clk_i);
      wb_xfer(1'b1, 8'h80, 32'h1 << k);
      wait_irq(1'b0);
    end
    supply_fault_i <= 8'h80;
    repeat (2) @(posedge clk_i);
    supply_fault_i <= 8'h0;
    wait_irq(1'b1);
    wb_xfer(1'b1, 8'h30, 32'h40);
    wait_irq(1'b0);
    wb_xfer(1'b1, 8'h30, 32'hc0);
    wait_irq(1'b1);
    wb_xfer(1'b1, 8'h84, 32'h0);
    wait_irq(1'b0);
    wb_xfer(1'b1, 8'h84, 32'hff);
    wait_irq(1'b1);
    repeat (4) @(posedge clk_i);
    wb_xfer(1'b1, 8'h38, 32'hc000);
    wait_irq(1'b0);
  endtask

  // A clear while the fault is still present loses to the fault
  task clear_refused;
    @(posedge clk_i);
    supply_fault_i <= 8'h01;
    wait_irq(1'b1);
    wb_xfer(1'b1, 8'h38, 32'h3);
    wb_xfer(1'b0, 8'h38, 32'h0);
    chk("set_wins", rd_val, 32'h2);
    supply_fault_i <= 8'h00;
    repeat (4) @(posedge clk_i);
    wb_xfer(1'b1, 8'h38, 32'h3);
    wait_irq(1'b0);
  endtask

  task reset_again;
    wb_xfer(1'b1, 8'h30, 32'h0000_0055);
    wb_xfer(1'b0, 8'h30, 32'h0);
    chk("en_all_off", rd_val, 32'h0);
    wb_xfer(1'b1, 8'h84, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, 8'h30, 32'h0);
    chk("led_en_rst", rd_val, 32'h0000_00aa);
    wb_xfer(1'b0, 8'h84, 32'h0);
    chk("mask_rst", rd_val, 32'h0000_00ff);
    chk("irq_rst", {31'h0, irq_o}, 32'h0);
  endtask

  initial
  begin
    miscompares     = 0;
    samples_checked = 0;
    rst_i           = 1'b1;
    wb_cyc_i        = 1'b0;
    wb_stb_i        = 1'b0;
    wb_we_i         = 1'b0;
    wb_adr_i        = 8'h0;
    wb_sel_i        = 4'h0;
    wb_dat_i        = 32'h0;
    supply_fault_i  = 8'h0;
    led_event_i     = 3'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    enable_fields();
    supply_faults();
    irq_gating();
    clear_refused();
    reset_again();
    tally_and_finish();
  end
endmodule
